// ---- msqc_params.svh ----
`ifndef MSQC_PARAMS_SVH
`define MSQC_PARAMS_SVH

// Register map
`define MSQC_ADDR_CFG 8'h12
`define MSQC_CFG_RESET 8'h02

// Field positions of the configuration byte
`define MSQC_BIT_DC_BYPASS 7
`define MSQC_POS_MOD_HI 6
`define MSQC_POS_MOD_LO 4
`define MSQC_BIT_MANCH 3
`define MSQC_POS_SYNC_HI 2
`define MSQC_POS_SYNC_LO 0

// Match thresholds
`define MSQC_THR_16_TOL 6'd15
`define MSQC_THR_16_EXACT 6'd16
`define MSQC_THR_32 6'd30

`endif

// ---- msqc_pkg.sv ----
package msqc_pkg;

  typedef enum logic [2:0]
  {
    MSQC_MOD_2FSK = 3'h0,
    MSQC_MOD_GFSK = 3'h1,
    MSQC_MOD_ASK = 3'h3,
    MSQC_MOD_4FSK = 3'h4,
    MSQC_MOD_MSK = 3'h7
  } msqc_mod_t;

  typedef enum logic [2:0]
  {
    MSQC_SYNC_NONE = 3'h0,
    MSQC_SYNC_15_16 = 3'h1,
    MSQC_SYNC_16_16 = 3'h2,
    MSQC_SYNC_30_32 = 3'h3,
    MSQC_SYNC_CS = 3'h4,
    MSQC_SYNC_15_16_CS = 3'h5,
    MSQC_SYNC_16_16_CS = 3'h6,
    MSQC_SYNC_30_32_CS = 3'h7
  } msqc_sync_t;

  typedef enum logic [1:0]
  {
    MSQC_TX_IDLE = 2'b00,
    MSQC_TX_PREAMBLE = 2'b01,
    MSQC_TX_SYNC = 2'b10,
    MSQC_TX_DATA = 2'b11
  } msqc_tx_state_t;

endpackage

// ---- msqc_sync_corr.sv ----
`timescale 1ns/1ns
`include "msqc_params.svh"

module msqc_sync_corr
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Decoded bit stream
  input wire logic bit_valid,
  input wire logic bit_in,
  // Pattern and mode
  input wire logic [15:0] sync_word,
  input wire logic long_mode,
  input wire logic tolerant,
  // Result
  output logic hit
);

  logic [31:0] shift;
  logic [31:0] next_shift;
  logic [31:0] pattern;
  logic [31:0] agree;
  logic [5:0] count;
  logic [5:0] threshold;
  logic [4:0] filled;

  assign next_shift = {shift[30:0], bit_in};
  assign pattern = {sync_word, sync_word};

  // Agreement per bit; the upper half only counts for the repeated word
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_agree
      if (i < 16)
      begin : g_low
        assign agree[i] = ~(next_shift[i] ^ pattern[i]);
      end
      else
      begin : g_high
        assign agree[i] = long_mode & ~(next_shift[i] ^ pattern[i]);
      end
    end
  endgenerate

  always_comb
  begin
    count = 6'h00;
    for (int k = 0; k < 32; k++)
    begin
      count = count + {5'h00, agree[k]};
    end
  end

  assign threshold = long_mode ? `MSQC_THR_32 :
                     (tolerant ? `MSQC_THR_16_TOL : `MSQC_THR_16_EXACT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift <= 32'h0000_0000;
      filled <= 5'h00;
      hit <= 1'b0;
    end
    else if (ce)
    begin
      hit <= bit_valid && (filled == 5'h1F) && (count >= threshold);
      if (bit_valid)
      begin
        shift <= next_shift;
        filled <= (filled == 5'h1F) ? filled : filled + 5'h01;
      end
    end
  end

endmodule

// ---- msqc_top.sv ----
`timescale 1ns/1ns
`include "msqc_params.svh"

// Summary of operation
// - Bit 7 low runs the DC blocking filter; high bypasses it.
// - Modulation code decodes to 2-FSK, GFSK, ASK/OOK, 4-FSK, MSK; others undefined.
// - Manchester bit set encodes transmit data and decodes receive data.
// - Codes 000 and 100 send no preamble or sync and search for none.
// - Codes 001, 010, 101, 110 send and detect one 16-bit sync word.
// - Codes 001 and 101 accept a sync match of 15 out of 16 bits.
// - Codes 011 and 111 send the word twice; match needs 30 of 32.
// - Codes 100, 101, 110, 111 also require carrier sense above threshold.

module msqc_top
#(
  parameter int SAMPLE_W = 12,
  parameter int DC_SHIFT = 6,
  parameter int PREAMBLE_BITS = 32
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WE,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Decoded configuration
  output msqc_pkg::msqc_mod_t MODULATION,
  output logic MOD_UNDEFINED,
  output msqc_pkg::msqc_sync_t SYNC_MODE,
  output logic DC_BYPASS,
  // Demodulator front end
  input wire logic SAMPLE_VALID,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_IN,
  output logic DEMOD_VALID,
  output logic signed [SAMPLE_W-1:0] DEMOD_SAMPLE,
  // Transmit framing
  input wire logic SYM_TICK,
  input wire logic [15:0] SYNC_WORD,
  input wire logic TX_START,
  input wire logic TX_DATA_VALID,
  input wire logic TX_DATA,
  input wire logic TX_DATA_LAST,
  output logic TX_DATA_READY,
  output logic TX_CHIP,
  output logic TX_ACTIVE,
  // Receive qualification
  input wire logic RX_CHIP_VALID,
  input wire logic RX_CHIP,
  input wire logic CARRIER_SENSE,
  input wire logic RX_RESTART,
  output logic RX_SYNC_FOUND,
  output logic RX_CODE_ERR,
  output logic RX_DATA_VALID,
  output logic RX_DATA
);

  import msqc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and configuration register

  logic [1:0] rst_sync;
  logic rst_n;
  logic [7:0] cfg;
  logic cfg_sel;
  logic manch;
  logic [2:0] mod_code;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  assign cfg_sel = (REG_ADDR == `MSQC_ADDR_CFG);

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      cfg <= `MSQC_CFG_RESET;
    else if (CE && REG_WE && cfg_sel)
      cfg <= REG_WDATA;
  end

  assign REG_RDATA = cfg_sel ? cfg : 8'h00;
  assign DC_BYPASS = cfg[`MSQC_BIT_DC_BYPASS];
  assign manch = cfg[`MSQC_BIT_MANCH];
  assign mod_code = cfg[`MSQC_POS_MOD_HI:`MSQC_POS_MOD_LO];
  assign MODULATION = msqc_mod_t'(mod_code);
  assign MOD_UNDEFINED = (mod_code == 3'h2) || (mod_code == 3'h5) || (mod_code == 3'h6);
  assign SYNC_MODE = msqc_sync_t'(cfg[`MSQC_POS_SYNC_HI:`MSQC_POS_SYNC_LO]);

  // Qualifier decode
  logic no_sync;
  logic long_sync;
  logic tolerant;
  logic need_cs;

  assign no_sync = (SYNC_MODE == MSQC_SYNC_NONE) || (SYNC_MODE == MSQC_SYNC_CS);
  assign long_sync = (SYNC_MODE == MSQC_SYNC_30_32) || (SYNC_MODE == MSQC_SYNC_30_32_CS);
  assign tolerant = (SYNC_MODE == MSQC_SYNC_15_16) || (SYNC_MODE == MSQC_SYNC_15_16_CS);
  assign need_cs = SYNC_MODE[2];

  ////////////////////////////////////////////////////////////////////////////////
  // DC blocking filter: leaky integrator estimate subtracted from each sample

  localparam int ACC_W = SAMPLE_W + DC_SHIFT;
  logic signed [ACC_W-1:0] dc_acc;
  logic signed [SAMPLE_W-1:0] dc_est;
  logic signed [SAMPLE_W-1:0] dc_out;

  assign dc_est = SAMPLE_W'(dc_acc >>> DC_SHIFT);
  assign dc_out = SAMPLE_IN - dc_est;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dc_acc <= '0;
      DEMOD_VALID <= 1'b0;
      DEMOD_SAMPLE <= '0;
    end
    else if (CE)
    begin
      DEMOD_VALID <= SAMPLE_VALID;
      if (SAMPLE_VALID)
      begin
        // Bypass freezes the estimate so re-enabling resumes smoothly
        DEMOD_SAMPLE <= DC_BYPASS ? SAMPLE_IN : dc_out;
        if (!DC_BYPASS)
          dc_acc <= dc_acc + ACC_W'(dc_out);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit framer and Manchester encoder

  msqc_tx_state_t tx_state;
  msqc_tx_state_t next_tx_state;
  logic [5:0] tx_cnt;
  logic tx_half;
  logic tx_bit;
  logic tx_hold;
  logic fetch;
  logic [5:0] sync_last;
  logic src_bit;

  assign fetch = CE && SYM_TICK && !tx_half && (tx_state != MSQC_TX_IDLE);
  assign sync_last = long_sync ? 6'd31 : 6'd15;
  assign TX_DATA_READY = fetch && (tx_state == MSQC_TX_DATA);
  assign TX_ACTIVE = (tx_state != MSQC_TX_IDLE) || tx_half;

  always_comb
  begin
    unique case (tx_state)
      MSQC_TX_PREAMBLE: src_bit = ~tx_cnt[0];
      MSQC_TX_SYNC: src_bit = SYNC_WORD[4'hF - tx_cnt[3:0]];
      default: src_bit = TX_DATA;
    endcase
  end

  always_comb
  begin
    next_tx_state = tx_state;
    unique case (tx_state)
      MSQC_TX_IDLE:
        if (TX_START)
          next_tx_state = no_sync ? MSQC_TX_DATA : MSQC_TX_PREAMBLE;
      MSQC_TX_PREAMBLE:
        if (fetch && tx_cnt == 6'(PREAMBLE_BITS - 1))
          next_tx_state = MSQC_TX_SYNC;
      MSQC_TX_SYNC:
        if (fetch && tx_cnt == sync_last)
          next_tx_state = MSQC_TX_DATA;
      MSQC_TX_DATA:
        if (fetch && (!TX_DATA_VALID || TX_DATA_LAST))
          next_tx_state = MSQC_TX_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state <= MSQC_TX_IDLE;
      tx_cnt <= 6'h00;
      tx_half <= 1'b0;
      tx_bit <= 1'b0;
      tx_hold <= 1'b0;
      TX_CHIP <= 1'b0;
    end
    else if (CE)
    begin
      tx_state <= next_tx_state;
      if (next_tx_state != tx_state)
        tx_cnt <= 6'h00;
      else if (fetch)
        tx_cnt <= tx_cnt + 6'h01;
      if (fetch && !(tx_state == MSQC_TX_DATA && !TX_DATA_VALID))
      begin
        tx_bit <= src_bit;
        TX_CHIP <= src_bit;
        tx_half <= manch;
      end
      else if (SYM_TICK && tx_half)
      begin
        TX_CHIP <= ~tx_bit;
        tx_half <= 1'b0;
      end
      tx_hold <= tx_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Manchester decoder and sync qualification

  logic rx_phase;
  logic rx_first;
  logic dec_valid;
  logic dec_bit;
  logic corr_hit;
  logic locked;
  logic lock_now;

  msqc_sync_corr u_corr
  (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .bit_valid(dec_valid),
    .bit_in(dec_bit),
    .sync_word(SYNC_WORD),
    .long_mode(long_sync),
    .tolerant(tolerant),
    .hit(corr_hit)
  );

  assign lock_now = !locked && !RX_RESTART &&
                    (no_sync ? (!need_cs || CARRIER_SENSE)
                             : (corr_hit && (!need_cs || CARRIER_SENSE)));

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_phase <= 1'b0;
      rx_first <= 1'b0;
      dec_valid <= 1'b0;
      dec_bit <= 1'b0;
      locked <= 1'b0;
      RX_CODE_ERR <= 1'b0;
      RX_SYNC_FOUND <= 1'b0;
      RX_DATA_VALID <= 1'b0;
      RX_DATA <= 1'b0;
    end
    else if (CE)
    begin
      dec_valid <= 1'b0;
      RX_CODE_ERR <= 1'b0;
      if (RX_CHIP_VALID)
      begin
        if (!manch)
        begin
          dec_valid <= 1'b1;
          dec_bit <= RX_CHIP;
        end
        else if (!rx_phase)
        begin
          rx_first <= RX_CHIP;
          rx_phase <= 1'b1;
        end
        else if (rx_first != RX_CHIP)
        begin
          dec_valid <= 1'b1;
          dec_bit <= rx_first;
          rx_phase <= 1'b0;
        end
        else
        begin
          // Violation: slip one chip to regain pair alignment
          RX_CODE_ERR <= 1'b1;
          rx_first <= RX_CHIP;
        end
      end
      RX_SYNC_FOUND <= lock_now && (SYNC_MODE != MSQC_SYNC_NONE);
      locked <= RX_RESTART ? 1'b0 : (locked || lock_now);
      RX_DATA_VALID <= locked && dec_valid;
      RX_DATA <= dec_bit;
    end
  end

endmodule

// ---- msqc_monitor.sv ----
`timescale 1ns/1ns

module msqc_monitor
#(
  parameter int SAMPLE_W = 12
)
(
  // Clock, reset and register port
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WE,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Decoded configuration
  input wire msqc_pkg::msqc_mod_t MODULATION,
  input wire logic MOD_UNDEFINED,
  input wire msqc_pkg::msqc_sync_t SYNC_MODE,
  input wire logic DC_BYPASS,
  // Samples and receive status
  input wire logic SAMPLE_VALID,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_IN,
  input wire logic DEMOD_VALID,
  input wire logic signed [SAMPLE_W-1:0] DEMOD_SAMPLE,
  input wire logic CARRIER_SENSE,
  input wire logic RX_SYNC_FOUND
);
  import msqc_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_reset_value: assert property ($rose(RESETN) |-> REG_ADDR != 8'h12 || REG_RDATA == 8'h02)
    else $error("config byte not 0x02 after reset");
  a_unmapped_zero: assert property (REG_ADDR != 8'h12 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_dc_bit: assert property (REG_ADDR == 8'h12 |-> DC_BYPASS == REG_RDATA[7])
    else $error("bypass output differs from bit 7");
  a_mod_field: assert property (REG_ADDR == 8'h12 |-> MODULATION == REG_RDATA[6:4])
    else $error("modulation output differs from field");
  a_mod_undef: assert property (MOD_UNDEFINED == (MODULATION inside {3'h2, 3'h5, 3'h6}))
    else $error("undefined flag wrong");
  a_sync_field: assert property (REG_ADDR == 8'h12 |-> SYNC_MODE == REG_RDATA[2:0])
    else $error("sync mode differs from field");
  a_write_taken: assert property (CE && REG_WE && REG_ADDR == 8'h12 |=>
    {DC_BYPASS, MODULATION, SYNC_MODE} == {$past(REG_WDATA[7:4]), $past(REG_WDATA[2:0])})
    else $error("write not applied");
  a_no_sync_pulse: assert property (SYNC_MODE == MSQC_SYNC_NONE |-> !RX_SYNC_FOUND)
    else $error("lock pulse in mode 000");
  a_cs_gate: assert property (SYNC_MODE[2] && !CARRIER_SENSE && $past(!CARRIER_SENSE)
    |-> !RX_SYNC_FOUND)
    else $error("lock without carrier sense");
  a_bypass_pass: assert property (CE && SAMPLE_VALID && DC_BYPASS |=>
    DEMOD_VALID && DEMOD_SAMPLE == $past(SAMPLE_IN))
    else $error("bypassed sample altered");

  c_lock: cover property (RX_SYNC_FOUND);
  c_write: cover property (CE && REG_WE && REG_ADDR == 8'h12);
  c_bypass: cover property (DEMOD_VALID && DC_BYPASS);
endmodule

bind msqc_top msqc_monitor #(.SAMPLE_W(SAMPLE_W)) u_mon (.CLK(CLK), .RESETN(RESETN), .CE(CE),
  .REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .MODULATION(MODULATION), .MOD_UNDEFINED(MOD_UNDEFINED), .SYNC_MODE(SYNC_MODE),
  .DC_BYPASS(DC_BYPASS), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_IN(SAMPLE_IN),
  .DEMOD_VALID(DEMOD_VALID), .DEMOD_SAMPLE(DEMOD_SAMPLE), .CARRIER_SENSE(CARRIER_SENSE),
  .RX_SYNC_FOUND(RX_SYNC_FOUND));

// ---- msqc_peer.sv ----
`timescale 1ns/1ns

module msqc_peer
(
  // Clock and transmit side
  input wire logic clk,
  input wire logic sym_tick,
  input wire logic tx_chip,
  // Receive side
  output logic rx_valid,
  output logic rx_chip
);
  logic [95:0] tx_sr;

  initial
  begin
    rx_valid = 1'b0;
    rx_chip = 1'b0;
    tx_sr = '0;
  end

  // Chip launched on one tick is still on the line at the next
  always @(posedge clk)
    if (sym_tick)
      tx_sr <= {tx_sr[94:0], tx_chip};

  task automatic chip(input logic c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_chip <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_chip <= ~c;
    repeat (2) @(posedge clk);
  endtask

  // Sends n bits MSB first, as chip pairs when m is set
  task automatic bits(input logic [63:0] v, input int n, input logic m);
    for (int i = n - 1; i >= 0; i--)
    begin
      chip(v[i]);
      if (m)
        chip(~v[i]);
    end
  endtask
endmodule

// ---- msqc_top_test.sv ----
`timescale 1ns/1ns

module msqc_top_test;
  import msqc_pkg::*;
  logic CLK, RESETN, CE, REG_WE, SAMPLE_VALID, SYM_TICK, TX_START, TX_DATA_VALID, TX_DATA;
  logic TX_DATA_LAST, RX_RESTART, CARRIER_SENSE, MOD_UNDEFINED, DC_BYPASS, DEMOD_VALID;
  logic TX_DATA_READY, TX_CHIP, TX_ACTIVE, RX_CHIP_VALID, RX_CHIP, RX_SYNC_FOUND, RX_CODE_ERR;
  logic RX_DATA_VALID, RX_DATA;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, dsr;
  logic signed [11:0] SAMPLE_IN, DEMOD_SAMPLE;
  msqc_mod_t MODULATION;
  msqc_sync_t SYNC_MODE;
  logic [15:0] SYNC_WORD;
  logic [1:0] tk;
  int miscompares, check_count, nf, nd, ne, e0, nr;

  msqc_top uut (.CLK(CLK), .RESETN(RESETN), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WE(REG_WE),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MODULATION(MODULATION),
    .MOD_UNDEFINED(MOD_UNDEFINED), .SYNC_MODE(SYNC_MODE), .DC_BYPASS(DC_BYPASS),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_IN(SAMPLE_IN), .DEMOD_VALID(DEMOD_VALID),
    .DEMOD_SAMPLE(DEMOD_SAMPLE), .SYM_TICK(SYM_TICK), .SYNC_WORD(SYNC_WORD),
    .TX_START(TX_START), .TX_DATA_VALID(TX_DATA_VALID), .TX_DATA(TX_DATA),
    .TX_DATA_LAST(TX_DATA_LAST), .TX_DATA_READY(TX_DATA_READY), .TX_CHIP(TX_CHIP),
    .TX_ACTIVE(TX_ACTIVE), .RX_CHIP_VALID(RX_CHIP_VALID), .RX_CHIP(RX_CHIP),
    .CARRIER_SENSE(CARRIER_SENSE), .RX_RESTART(RX_RESTART), .RX_SYNC_FOUND(RX_SYNC_FOUND),
    .RX_CODE_ERR(RX_CODE_ERR), .RX_DATA_VALID(RX_DATA_VALID), .RX_DATA(RX_DATA));
  msqc_peer peer (.clk(CLK), .sym_tick(SYM_TICK), .tx_chip(TX_CHIP), .rx_valid(RX_CHIP_VALID),
    .rx_chip(RX_CHIP));

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Chip tick every fourth cycle, receive event counters and a transmit ready counter
  always @(posedge CLK)
  begin
    tk <= tk + 2'h1;
    SYM_TICK <= tk == 2'h3;
    nf <= nf + int'(RX_SYNC_FOUND === 1'b1);
    nd <= nd + int'(RX_DATA_VALID === 1'b1);
    ne <= ne + int'(RX_CODE_ERR === 1'b1);
    nr <= nr + int'(TX_DATA_READY === 1'b1);
    if (RX_DATA_VALID === 1'b1)
      dsr <= {dsr[6:0], RX_DATA};
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WE <= 1'b1;
    @(posedge CLK);
    REG_WE <= 1'b0;
    @(negedge CLK);
  endtask

  task automatic rxc(input logic [2:0] md, input logic mc, cs, input logic [31:0] em, int ex);
    int f0, d0;
    wr(8'h12, {4'h0, mc, md});
    @(posedge CLK);
    CARRIER_SENSE <= cs;
    RX_RESTART <= 1'b1;
    @(posedge CLK);
    RX_RESTART <= 1'b0;
    f0 = nf;
    d0 = nd;
    peer.bits(64'hAAAAAAAA, 32, mc);
    peer.bits({32'h0, SYNC_WORD, SYNC_WORD} ^ em, (md[1:0] == 2'h3) ? 32 : 16, mc);
    peer.bits(64'hB4, 8, mc);
    repeat (8) @(posedge CLK);
    @(negedge CLK);
    chk("sync", 16'(ex), 16'(nf - f0));
    if (md == 3'h2)
      chk("data", ex ? 16'h08B4 : 16'h0000, {8'(nd - d0), ex ? dsr : 8'h00});
  endtask

  task automatic txc(input logic [7:0] cfg, input logic p, input logic [47:0] pat, input int n);
    int r0;
    logic f;
    f = 1'b0;
    wr(8'h12, cfg);
    r0 = nr;
    @(posedge CLK);
    {TX_DATA, TX_DATA_VALID, TX_DATA_LAST, TX_START} <= {p, 3'h7};
    @(posedge CLK);
    TX_START <= 1'b0;
    @(posedge CLK);
    for (int i = 0; i < 2000 && TX_ACTIVE !== 1'b0; i++)
      @(posedge CLK);
    TX_DATA_VALID <= 1'b0;
    repeat (40) @(posedge CLK);
    for (int i = 0; i < 48; i++)
      f |= ((peer.tx_sr >> i) & ((96'h1 << n) - 96'h1)) == 96'(pat);
    chk("tx", 16'h1, 16'(f));
    chk("ready", 16'h1, 16'(nr - r0));
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge CLK);
    miscompares++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {RESETN, REG_WE, SAMPLE_VALID, TX_START, TX_DATA_VALID, TX_DATA, TX_DATA_LAST} = '0;
    {RX_RESTART, CARRIER_SENSE, SYM_TICK, tk, dsr, SAMPLE_IN, REG_WDATA} = '0;
    CE = 1'b1;
    REG_ADDR = 8'h12;
    SYNC_WORD = 16'hD391;
    repeat (16) @(posedge CLK);
    @(negedge CLK);
    chk("rst", 16'h02, REG_RDATA);
    @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    wr(8'h13, 8'hFF);
    chk("unmap", 16'h00, REG_RDATA);
    wr(8'h12, 8'h02);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h12, {1'b0, 3'(m), 4'hA});
      chk("cfg", {9'h0, 3'(m), 4'hA}, REG_RDATA);
      chk("mod", 16'(m), MODULATION);
      chk("undef", 16'(m == 2 || m == 5 || m == 6), MOD_UNDEFINED);
    end
    // Writes are ignored while the clock enable is low
    @(posedge CLK);
    CE <= 1'b0;
    wr(8'h12, 8'h55);
    chk("hold", 16'h7A, REG_RDATA);
    @(posedge CLK);
    CE <= 1'b1;
    $display("register test done");
    wr(8'h12, 8'h82);
    @(posedge CLK);
    {SAMPLE_VALID, SAMPLE_IN} <= {1'b1, 12'hED4};
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    @(negedge CLK);
    chk("byp", 16'h0ED4, {4'h0, DEMOD_SAMPLE});
    wr(8'h12, 8'h02);
    @(posedge CLK);
    {SAMPLE_VALID, SAMPLE_IN} <= {1'b1, 12'h190};
    repeat (800) @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    @(negedge CLK);
    chk("dcblk", 16'h1, 16'(DEMOD_SAMPLE < 12'sd64));
    $display("filter test done");
    rxc(3'h1, 1'b0, 1'b0, 32'h10, 1);
    rxc(3'h2, 1'b0, 1'b0, 32'h10, 0);
    rxc(3'h2, 1'b1, 1'b0, 32'h0, 1);
    e0 = ne;
    peer.chip(1'b1);
    peer.chip(1'b1);
    @(negedge CLK);
    chk("cerr", 16'h1, 16'(ne - e0));
    rxc(3'h3, 1'b0, 1'b0, 32'h10100, 1);
    rxc(3'h3, 1'b0, 1'b0, 32'h1010100, 0);
    rxc(3'h5, 1'b0, 1'b0, 32'h10, 0);
    rxc(3'h5, 1'b0, 1'b1, 32'h10, 1);
    rxc(3'h6, 1'b0, 1'b1, 32'h0, 1);
    rxc(3'h7, 1'b0, 1'b1, 32'h10100, 1);
    rxc(3'h7, 1'b0, 1'b0, 32'h0, 0);
    rxc(3'h4, 1'b0, 1'b1, 32'h0, 1);
    rxc(3'h4, 1'b0, 1'b0, 32'h0, 0);
    rxc(3'h0, 1'b0, 1'b0, 32'h0, 0);
    $display("receive test done");
    txc(8'h03, 1'b1, {4'hA, SYNC_WORD, SYNC_WORD, 1'b1}, 37);
    txc(8'h02, 1'b1, {4'hA, SYNC_WORD, 1'b1}, 21);
    txc(8'h00, 1'b0, 48'h1FE, 9);
    txc(8'h08, 1'b0, 48'h001, 9);
    $display("transmit test done");
    end_sim();
  end
endmodule
